// *** logic/nra_pulse_gen.sv ***
// Retriggerable fixed-length reset pulse timed by a cycle counter
`timescale 1ns/100ps
module nra_pulse_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic trig,
  output logic pulse
);
  import nra_pkg::*;

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic pulse_reg;
  logic pulse_next;

  // --------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------
  // counter sets pulse length
  always_comb
  begin
    cnt_next = cnt_reg;
    if (trig)
    begin
      cnt_next = PULSE_CYCLES;
    end
    else if (cnt_reg != 5'h00)
    begin
      cnt_next = cnt_reg - 5'h01;
    end
    // Pulse ends exactly when the count is spent, never before
    pulse_next = (cnt_next != 5'h00);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 5'h00;
      pulse_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse = pulse_reg;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_pulse_start: assert property (
    @(posedge clk) disable iff (rst)
    trig |=> pulse && cnt_reg == PULSE_CYCLES)
    else $error("pulse did not start with full count");

  a_pulse_end: assert property (
    @(posedge clk) disable iff (rst)
    (cnt_reg == 5'h01 && !trig) |=> !pulse && cnt_reg == 5'h00)
    else $error("pulse outlived its counter");

endmodule

// *** logic/nra_reset_top.sv ***
`timescale 1ns/100ps
module nra_reset_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic LOW_SUPPLY_RESET,
  input wire logic [nra_pkg::STRAP_W-1:0] STRAP_PINS,
  input wire logic BUS_RESET_N,
  input wire logic SEL_RESET_STROBE,
  input wire nra_pkg::nra_sections_t SEL_RESET_MASK,
  input wire logic EE_ACK,
  input wire logic [15:0] EE_DATA,
  output logic EE_REQ,
  output logic [7:0] EE_ADDR,
  output logic [nra_pkg::STRAP_W-1:0] STRAP_OPTIONS,
  output logic PAD_DISABLE,
  output nra_pkg::nra_sections_t SECTION_RESETS,
  output nra_pkg::nra_autoload_t LOADED,
  output logic LOAD_DONE
);
  import nra_pkg::*;

  function automatic logic [7:0] load_addr(input logic [2:0] idx);
    unique case (idx)
      LOAD_IDX_DEVICE_ID: load_addr = EE_ADDR_DEVICE_ID;
      LOAD_IDX_BUS_PARAM: load_addr = EE_ADDR_BUS_PARAM;
      LOAD_IDX_NODE_ADDR0: load_addr = EE_ADDR_NODE_ADDR0;
      LOAD_IDX_SETUP_LO: load_addr = EE_ADDR_SETUP_LO;
      default: load_addr = EE_ADDR_SETUP_HI;
    endcase
  endfunction

  // --------------------------------------------------------------
  // Core reset
  // --------------------------------------------------------------
  // low supply joins the core reset
  logic core_rst;
  assign core_rst = RESET | LOW_SUPPLY_RESET;

  // --------------------------------------------------------------
  // Input synchronisers and strap capture
  // --------------------------------------------------------------
  logic [STRAP_W-1:0] strap_sync1_reg;
  logic [STRAP_W-1:0] strap_sync2_reg;
  logic bus_sync1_reg;
  logic bus_sync2_reg;
  logic bus_prev_reg;
  logic [1:0] strap_cnt_reg;
  logic [1:0] strap_cnt_next;
  logic strap_done_reg;
  logic strap_done_next;
  logic [STRAP_W-1:0] strap_opt_reg;
  logic [STRAP_W-1:0] strap_opt_next;

  always_comb
  begin
    strap_cnt_next = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    strap_opt_next = strap_opt_reg;
    // Wait for the synchroniser to fill before trusting the straps
    if (!strap_done_reg)
    begin
      if (strap_cnt_reg == STRAP_SETTLE)
      begin
        strap_opt_next = strap_sync2_reg;
        strap_done_next = 1'b1;
      end
      else
      begin
        strap_cnt_next = strap_cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge CLK or posedge core_rst)
  begin
    if (core_rst)
    begin
      strap_sync1_reg <= STRAP_RESET;
      strap_sync2_reg <= STRAP_RESET;
      bus_sync1_reg <= 1'b1;
      bus_sync2_reg <= 1'b1;
      bus_prev_reg <= 1'b1;
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      strap_opt_reg <= STRAP_RESET;
    end
    else
    begin
      strap_sync1_reg <= STRAP_PINS;
      strap_sync2_reg <= strap_sync1_reg;
      bus_sync1_reg <= BUS_RESET_N;
      bus_sync2_reg <= bus_sync1_reg;
      bus_prev_reg <= bus_sync2_reg;
      strap_cnt_reg <= strap_cnt_next;
      strap_done_reg <= strap_done_next;
      strap_opt_reg <= strap_opt_next;
    end
  end

  // --------------------------------------------------------------
  // Edge pulses
  // --------------------------------------------------------------
  logic fall_trig;
  logic rise_trig;
  logic sel_trig;
  logic fall_edge_reset_pulse;
  logic rise_edge_reset_pulse;
  logic sel_pulse;

  assign fall_trig = bus_prev_reg & ~bus_sync2_reg;
  assign rise_trig = ~bus_prev_reg & bus_sync2_reg;
  // only a nonempty mask starts a pulse
  assign sel_trig = SEL_RESET_STROBE & (|SEL_RESET_MASK);

  nra_pulse_gen u_fall (
    .clk(CLK),
    .rst(core_rst),
    .trig(fall_trig),
    .pulse(fall_edge_reset_pulse)
  );

  nra_pulse_gen u_rise (
    .clk(CLK),
    .rst(core_rst),
    .trig(rise_trig),
    .pulse(rise_edge_reset_pulse)
  );

  nra_pulse_gen u_sel (
    .clk(CLK),
    .rst(core_rst),
    .trig(sel_trig),
    .pulse(sel_pulse)
  );

  // --------------------------------------------------------------
  // Section resets and pad disable
  // --------------------------------------------------------------
  nra_sections_t sel_mask_reg;
  nra_sections_t sel_mask_next;
  nra_sections_t sect_reg;
  nra_sections_t sect_next;
  nra_sections_t sel_active;
  logic pad_dis_reg;
  logic pad_dis_next;
  logic bus_any;

  always_comb
  begin
    sel_mask_next = sel_trig ? SEL_RESET_MASK : sel_mask_reg;
    sel_active = sel_pulse ? sel_mask_reg : SECTIONS_NONE;
    pad_dis_next = ~bus_sync2_reg;
    bus_any = fall_edge_reset_pulse | rise_edge_reset_pulse | pad_dis_reg;
    // bus reset limited to host-side sections
    sect_next.target = bus_any | sel_active.target;
    sect_next.master = bus_any | sel_active.master;
    sect_next.config_space = bus_any | sel_active.config_space;
    sect_next.heartbeat = rise_edge_reset_pulse | sel_active.heartbeat;
    sect_next.setup = sel_active.setup;
  end

  always_ff @(posedge CLK or posedge core_rst)
  begin
    if (core_rst)
    begin
      sel_mask_reg <= SECTIONS_NONE;
      sect_reg <= SECTIONS_NONE;
      pad_dis_reg <= 1'b0;
    end
    else
    begin
      sel_mask_reg <= sel_mask_next;
      sect_reg <= sect_next;
      pad_dis_reg <= pad_dis_next;
    end
  end

  // --------------------------------------------------------------
  // EEPROM autoload
  // --------------------------------------------------------------
  nra_load_state_t ld_state_reg;
  nra_load_state_t ld_state_next;
  logic [2:0] ld_idx_reg;
  logic [2:0] ld_idx_next;
  logic ld_pend_reg;
  logic ld_pend_next;
  nra_autoload_t loaded_reg;
  nra_autoload_t loaded_next;
  logic ee_req_reg;
  logic ee_req_next;
  logic [7:0] ee_addr_reg;
  logic [7:0] ee_addr_next;
  logic load_done_reg;
  logic load_done_next;

  always_comb
  begin
    ld_state_next = ld_state_reg;
    ld_idx_next = ld_idx_reg;
    loaded_next = loaded_reg;
    // A restart during a read waits so the EEPROM never sees a torn request
    ld_pend_next = ld_pend_reg | rise_trig | (sel_trig & SEL_RESET_MASK.setup);
    unique case (ld_state_reg)
      LD_REQ:
      begin
        if (EE_ACK && ee_req_reg)
        begin
          unique case (ld_idx_reg)
            LOAD_IDX_DEVICE_ID: loaded_next.device_identifier = EE_DATA;
            LOAD_IDX_BUS_PARAM: loaded_next.bus_parameter_word = EE_DATA;
            LOAD_IDX_NODE_ADDR0: loaded_next.node_address_word0 = EE_DATA;
            LOAD_IDX_SETUP_LO: loaded_next.internal_setup_register[15:0] = EE_DATA;
            default: loaded_next.internal_setup_register[31:16] = EE_DATA;
          endcase
          if (ld_idx_reg == LOAD_IDX_SETUP_HI)
          begin
            ld_state_next = LD_DONE;
          end
          else
          begin
            ld_idx_next = ld_idx_reg + 3'h1;
          end
        end
      end
      LD_DONE:
      begin
        if (ld_pend_reg)
        begin
          // A restart asked for in this very cycle wins over the clear
          ld_pend_next = rise_trig | (sel_trig & SEL_RESET_MASK.setup);
          ld_idx_next = LOAD_IDX_DEVICE_ID;
          ld_state_next = LD_REQ;
        end
      end
    endcase
    ee_req_next = (ld_state_next == LD_REQ);
    ee_addr_next = load_addr(ld_idx_next);
    load_done_next = (ld_state_next == LD_DONE);
  end

  always_ff @(posedge CLK or posedge core_rst)
  begin
    if (core_rst)
    begin
      ld_state_reg <= LD_REQ;
      ld_idx_reg <= LOAD_IDX_DEVICE_ID;
      ld_pend_reg <= 1'b0;
      loaded_reg <= '0;
      ee_req_reg <= 1'b0;
      ee_addr_reg <= EE_ADDR_DEVICE_ID;
      load_done_reg <= 1'b0;
    end
    else
    begin
      ld_state_reg <= ld_state_next;
      ld_idx_reg <= ld_idx_next;
      ld_pend_reg <= ld_pend_next;
      loaded_reg <= loaded_next;
      ee_req_reg <= ee_req_next;
      ee_addr_reg <= ee_addr_next;
      load_done_reg <= load_done_next;
    end
  end

  assign EE_REQ = ee_req_reg;
  assign EE_ADDR = ee_addr_reg;
  assign STRAP_OPTIONS = strap_opt_reg;
  assign PAD_DISABLE = pad_dis_reg;
  assign SECTION_RESETS = sect_reg;
  assign LOADED = loaded_reg;
  assign LOAD_DONE = load_done_reg;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_strap_capture: assert property (
    @(posedge CLK) disable iff (core_rst)
    $rose(strap_done_reg) |-> STRAP_OPTIONS == $past(strap_sync2_reg) ##1 $stable(STRAP_OPTIONS))
    else $error("strap options not captured once");

  a_supply_hold: assert property (
    @(posedge CLK) disable iff (RESET)
    LOW_SUPPLY_RESET |-> !strap_done_reg && ld_state_reg == LD_REQ && sect_reg == SECTIONS_NONE)
    else $error("state moved under low supply");

  a_bus_scope: assert property (
    @(posedge CLK) disable iff (core_rst)
    pad_dis_reg && !sel_pulse |=> SECTION_RESETS.target && SECTION_RESETS.config_space
      && !SECTION_RESETS.setup && $stable(STRAP_OPTIONS))
    else $error("bus reset reached the wrong sections");

  a_fall_pulse: assert property (
    @(posedge CLK) disable iff (core_rst)
    fall_trig |=> fall_edge_reset_pulse ##1 SECTION_RESETS.master)
    else $error("falling edge pulse missing");

  a_rise_pulse: assert property (
    @(posedge CLK) disable iff (core_rst)
    rise_trig |=> rise_edge_reset_pulse[*8])
    else $error("rising edge pulse too short");

  a_heartbeat_restart: assert property (
    @(posedge CLK) disable iff (core_rst)
    rise_trig |-> ##2 SECTION_RESETS.heartbeat)
    else $error("heartbeat not restarted");

  a_pad_disable: assert property (
    @(posedge CLK) disable iff (core_rst)
    !bus_sync2_reg |=> PAD_DISABLE ##1 SECTION_RESETS.target)
    else $error("pads not disabled in bus reset");

  a_sel_mask: assert property (
    @(posedge CLK) disable iff (core_rst)
    sel_trig && SEL_RESET_MASK.setup |-> ##2 SECTION_RESETS.setup)
    else $error("selected section not reset");

  a_device_id_load: assert property (
    @(posedge CLK) disable iff (core_rst)
    EE_REQ && EE_ACK && ld_idx_reg == LOAD_IDX_DEVICE_ID
      |-> EE_ADDR == EE_ADDR_DEVICE_ID ##1 LOADED.device_identifier == $past(EE_DATA))
    else $error("device identifier not loaded from word 03");

  a_setup_high: assert property (
    @(posedge CLK) disable iff (core_rst)
    EE_REQ && EE_ACK && ld_idx_reg == LOAD_IDX_SETUP_HI
      |=> LOADED.internal_setup_register[31:16] == $past(EE_DATA) && LOAD_DONE)
    else $error("setup high half not loaded");

endmodule

// *** shared/nra_pkg.sv ***
// Shared constants and types for the reset and configuration autoload block
package nra_pkg;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int EDGE_PULSE_NS = 1000;
  localparam logic [4:0] PULSE_CYCLES =
    5'((EDGE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // --------------------------------------------------------------
  // Widths and reset values
  // --------------------------------------------------------------
  localparam int STRAP_W = 8;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // --------------------------------------------------------------
  // Autoload word locations, in load order
  // --------------------------------------------------------------
  localparam logic [7:0] EE_ADDR_DEVICE_ID = 8'h03;
  localparam logic [7:0] EE_ADDR_BUS_PARAM = 8'h08;
  localparam logic [7:0] EE_ADDR_NODE_ADDR0 = 8'h0A;
  localparam logic [7:0] EE_ADDR_SETUP_LO = 8'h12;
  localparam logic [7:0] EE_ADDR_SETUP_HI = 8'h13;
  localparam logic [2:0] LOAD_IDX_DEVICE_ID = 3'h0;
  localparam logic [2:0] LOAD_IDX_BUS_PARAM = 3'h1;
  localparam logic [2:0] LOAD_IDX_NODE_ADDR0 = 3'h2;
  localparam logic [2:0] LOAD_IDX_SETUP_LO = 3'h3;
  localparam logic [2:0] LOAD_IDX_SETUP_HI = 3'h4;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef struct packed {
    logic setup;
    logic heartbeat;
    logic config_space;
    logic master;
    logic target;
  } nra_sections_t;

  localparam nra_sections_t SECTIONS_NONE = 5'h00;

  typedef struct packed {
    logic [31:0] internal_setup_register;
    logic [15:0] node_address_word0;
    logic [15:0] bus_parameter_word;
    logic [15:0] device_identifier;
  } nra_autoload_t;

  typedef enum logic [0:0] {LD_REQ, LD_DONE} nra_load_state_t;

endpackage

// *** verification/nra_ee_model.sv ***
// Behavioural EEPROM word reader that answers the autoload requests
`timescale 1ns/100ps
module nra_ee_model (
  input wire logic clk,
  input wire logic ee_req,
  input wire logic [7:0] ee_addr,
  input wire logic [1:0] wait_cycles,
  input wire logic [15:0] salt,
  output logic ee_ack,
  output logic [15:0] ee_data
);
  int cnt = 0;
  initial
  begin
    ee_ack = 1'b0;
    ee_data = 16'hA5A5;
  end
  // ----------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    #1;
    if (ee_req === 1'b1 && cnt >= wait_cycles)
    begin
      ee_ack = 1'b1;
      ee_data = {ee_addr, ee_addr ^ 8'h5A} ^ salt;
      cnt = 0;
    end
    else
    begin
      // Data is not held between answers, so a late sample cannot pass
      ee_ack = 1'b0;
      ee_data = ~ee_data;
      cnt = (ee_req === 1'b1) ? cnt + 1 : 0;
    end
  end
endmodule

// *** verification/nra_reset_top_bench.sv ***
// Self-checking testbench for the reset and autoload block
`timescale 1ns/100ps
module nra_reset_top_bench;
  import nra_pkg::*;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic LOW_SUPPLY_RESET = 1'b0;
  logic [STRAP_W-1:0] STRAP_PINS = 8'h00;
  logic BUS_RESET_N = 1'b1;
  logic SEL_RESET_STROBE = 1'b0;
  nra_sections_t SEL_RESET_MASK = SECTIONS_NONE;
  logic EE_ACK;
  logic [15:0] EE_DATA;
  logic EE_REQ;
  logic [7:0] EE_ADDR;
  logic [STRAP_W-1:0] STRAP_OPTIONS;
  logic PAD_DISABLE;
  nra_sections_t SECTION_RESETS;
  nra_autoload_t LOADED;
  logic LOAD_DONE;
  logic [1:0] wait_cycles = 2'h0;
  logic [15:0] salt = 16'h0000;
  logic [31:0] rs = 32'd58856;
  logic [7:0] addr_tab [5] = '{EE_ADDR_DEVICE_ID, EE_ADDR_BUS_PARAM, EE_ADDR_NODE_ADDR0,
    EE_ADDR_SETUP_LO, EE_ADDR_SETUP_HI};
  logic [15:0] words [$];
  nra_autoload_t exp_ld = '0;
  logic [STRAP_W-1:0] exp_strap;
  int ld_idx = 0;
  int errors = 0;
  int num_checks = 0;
  int n;
  always #25 CLK = ~CLK;
  nra_reset_top dut (.CLK(CLK), .RESET(RESET), .LOW_SUPPLY_RESET(LOW_SUPPLY_RESET),
    .STRAP_PINS(STRAP_PINS), .BUS_RESET_N(BUS_RESET_N), .SEL_RESET_STROBE(SEL_RESET_STROBE),
    .SEL_RESET_MASK(SEL_RESET_MASK), .EE_ACK(EE_ACK), .EE_DATA(EE_DATA), .EE_REQ(EE_REQ),
    .EE_ADDR(EE_ADDR), .STRAP_OPTIONS(STRAP_OPTIONS), .PAD_DISABLE(PAD_DISABLE),
    .SECTION_RESETS(SECTION_RESETS), .LOADED(LOADED), .LOAD_DONE(LOAD_DONE));
  nra_ee_model ee (.clk(CLK), .ee_req(EE_REQ), .ee_addr(EE_ADDR), .wait_cycles(wait_cycles),
    .salt(salt), .ee_ack(EE_ACK), .ee_data(EE_DATA));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge CLK);
    #2;
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Counts the cycles for which any bit of m stays high
  task automatic measure(input nra_sections_t m);
    n = 0;
    while ((SECTION_RESETS & m) !== 5'h00 && n < 100)
    begin
      n++;
      step();
    end
  endtask
  task automatic load_check();
    for (int k = 0; k < 60 && EE_REQ !== 1'b1; k++)
      step();
    for (int k = 0; k < 200 && !(LOAD_DONE === 1'b1 && EE_REQ === 1'b0); k++)
      step();
    check({LOAD_DONE, EE_REQ}, 2'h2);
    check(LOADED, exp_ld);
    repeat (10) step();
    check(EE_REQ, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // Reference model of the autoload sequence
  // ----------------------------------------------------------------
  always @(negedge CLK)
  begin
    if (RESET || LOW_SUPPLY_RESET)
    begin
      ld_idx = 0;
      words.delete();
      exp_ld = '0;
    end
    else if (EE_REQ === 1'b1 && EE_ACK === 1'b1)
    begin
      check(EE_ADDR, addr_tab[ld_idx]);
      words.push_back({addr_tab[ld_idx], addr_tab[ld_idx] ^ 8'h5A} ^ salt);
      ld_idx = (ld_idx + 1) % 5;
      if (words.size() == 5)
      begin
        exp_ld = {words[4], words[3], words[2], words[1], words[0]};
        words.delete();
      end
    end
  end
  initial
  begin
    #(50 * 20000);
    errors++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    exp_strap = STRAP_W'(rnd());
    STRAP_PINS = exp_strap;
    salt = 16'(rnd());
    #60;
    check({EE_REQ, STRAP_OPTIONS, SECTION_RESETS, LOADED, LOAD_DONE}, '0);
    @(posedge CLK);
    #2;
    RESET = 1'b0;
    load_check();
    check(STRAP_OPTIONS, exp_strap);
    STRAP_PINS = ~exp_strap;
    repeat (5) step();
    check(STRAP_OPTIONS, exp_strap);
    $display("Test power-on done");
    LOW_SUPPLY_RESET = 1'b1;
    exp_strap = STRAP_W'(rnd());
    STRAP_PINS = exp_strap;
    salt = 16'(rnd());
    wait_cycles = 2'h2;
    step();
    step();
    check({EE_REQ, STRAP_OPTIONS, SECTION_RESETS, LOADED, LOAD_DONE}, '0);
    LOW_SUPPLY_RESET = 1'b0;
    load_check();
    check(STRAP_OPTIONS, exp_strap);
    $display("Test low supply done");
    salt = 16'(rnd());
    wait_cycles = 2'h1;
    BUS_RESET_N = 1'b0;
    for (int k = 0; k < 8 && PAD_DISABLE !== 1'b1; k++)
      step();
    step();
    check(SECTION_RESETS, 5'h07);
    repeat (30) step();
    check({PAD_DISABLE, SECTION_RESETS, STRAP_OPTIONS, LOADED},
      {1'b1, 5'h07, exp_strap, exp_ld});
    BUS_RESET_N = 1'b1;
    for (int k = 0; k < 8 && PAD_DISABLE !== 1'b0; k++)
      step();
    check(PAD_DISABLE, 1'b0);
    for (int k = 0; k < 8 && SECTION_RESETS.heartbeat !== 1'b1; k++)
      step();
    measure(5'h08);
    check(n, PULSE_CYCLES);
    check(STRAP_OPTIONS, exp_strap);
    load_check();
    $display("Test bus reset done");
    for (int i = 0; i < 7; i++)
    begin
      SEL_RESET_MASK = (i < 5) ? 5'(1 << i) : ((i == 5) ? 5'(rnd() | 32'h1) : 5'h00);
      if (SEL_RESET_MASK.setup)
        salt = 16'(rnd());
      SEL_RESET_STROBE = 1'b1;
      step();
      SEL_RESET_STROBE = 1'b0;
      for (int k = 0; k < 6 && SECTION_RESETS === 5'h00; k++)
        step();
      check(SECTION_RESETS, SEL_RESET_MASK);
      measure(SEL_RESET_MASK);
      if (i < 6)
        check(n, PULSE_CYCLES);
      else
        check(n, 0);
      if (SEL_RESET_MASK.setup)
        load_check();
    end
    $display("Test selective reset done");
    close_out();
  end
endmodule
